// ---- psa_pkg.sv ----
package psa_pkg;
   localparam int CLK_HZ        = 10_000_000;
   localparam int SAMPLE_MS     = 50;
   localparam int TICK_CYCLES   = CLK_HZ / 1000 * SAMPLE_MS;
   localparam int MAX_WIN       = 400;
   localparam logic [15:0] DEF_MS_R0 = 16'h0AF0;
   localparam logic [15:0] DEF_MS_RX = 16'h0320;
   localparam int ZERO_RANGES   = 5;
   localparam int ZERO_TOTAL_MS = 5000;
   localparam int ZERO_TICKS    = ZERO_TOTAL_MS / SAMPLE_MS / ZERO_RANGES;
   localparam int NUM_SENSORS   = 4;
   localparam int NUM_RANGES    = 7;
   localparam int NUM_FPTS      = 36;
   localparam int UP_NOM        = 5000;
   localparam logic [15:0] CF_UNITY = 16'h4000;
   localparam int CF_SHIFT      = 14;
   localparam int SQ_SHIFT      = 24;
   localparam int DN_SHIFT      = 14;
   localparam int FLUSH_NUM     = 4616;
   localparam int FLUSH_DEN     = 1_000_000;
   localparam logic [23:0] FULL_SCALE_R0 = 24'hF0_0000;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_FILT = 12'h004;
   localparam logic [11:0] REG_FREQ = 12'h008;
   localparam logic [11:0] REG_CMD  = 12'h00C;
   localparam logic [11:0] REG_STAT = 12'h010;
   localparam logic [11:0] REG_AVG  = 12'h014;
   localparam logic [11:0] REG_CNT  = 12'h018;
   localparam logic [11:0] REG_ZOFF = 12'h040;
   localparam logic [11:0] REG_LIN  = 12'h100;
   localparam logic [11:0] REG_FCNT = 12'h1C0;
   localparam logic [11:0] REG_FPT  = 12'h200;
   localparam int CTRL_AUTO = 0;
   localparam int CTRL_HOLD = 1;
   localparam int CTRL_HRNG = 2;
   localparam int CTRL_SENS = 5;
   localparam int CTRL_UNIT = 7;
   localparam int CTRL_FEN  = 8;
   localparam logic [8:0]  CTRL_RESET = 9'h081;
   localparam logic [15:0] FILT_RESET = 16'h0032;
   localparam int ST_BUSY = 0;
   localparam int ST_ZERR = 1;
   localparam int ST_FERR = 2;
   typedef enum {P_IDLE, P_LIN, P_SCAN, P_IDIV, P_AVG, P_MDIV} psa_proc_t;
endpackage : psa_pkg

// ---- psa_div_if.sv ----
`timescale 1ns/1ns
interface psa_div_if #(parameter int DW = 48, parameter int VW = 32);
   logic          start;
   logic [DW-1:0] dividend;
   logic [VW-1:0] divisor;
   logic          busy;
   logic          done;
   logic [DW-1:0] quotient;
   modport master (output start, output dividend, output divisor, input busy, input done, input quotient);
   modport slave  (input start, input dividend, input divisor, output busy, output done, output quotient);
endinterface : psa_div_if

// ---- psa_div.sv ----
`timescale 1ns/1ns
// restoring divider, one quotient bit per cycle; a zero divisor gives all ones
module psa_div import psa_pkg::*; #(
   parameter int DW = 48,
   parameter int VW = 32
) (
   input wire logic core_clk,
   input wire logic rst,
   psa_div_if.slave dv
);
   logic [DW-1:0] q_q, q_d;
   logic [VW:0]   r_q, r_d;
   logic [VW-1:0] d_q, d_d;
   logic [6:0]    n_q, n_d;
   logic          busy_q, busy_d;
   logic          done_q, done_d;
   logic [VW:0]   shifted;
   logic [VW+1:0] trial;

   always_comb begin
      q_d = q_q;
      r_d = r_q;
      d_d = d_q;
      n_d = n_q;
      busy_d = busy_q;
      done_d = 1'b0;
      shifted = {r_q[VW-1:0], q_q[DW-1]};
      trial = {1'b0, shifted} - {2'b00, d_q};
      if (dv.start && !busy_q) begin
         q_d = dv.dividend;
         r_d = '0;
         d_d = dv.divisor;
         n_d = 7'(DW);
         busy_d = 1'b1;
      end else if (busy_q) begin
         if (!trial[VW+1]) begin
            r_d = trial[VW:0];
            q_d = {q_q[DW-2:0], 1'b1};
         end else begin
            r_d = shifted;
            q_d = {q_q[DW-2:0], 1'b0};
         end
         n_d = n_q - 7'h01;
         if (n_q == 7'h01) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q_q <= '0;
         r_q <= '0;
         d_q <= '0;
         n_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         q_q <= q_d;
         r_q <= r_d;
         d_q <= d_d;
         n_q <= n_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign dv.quotient = q_q;
   assign dv.busy = busy_q;
   assign dv.done = done_q;
endmodule : psa_div

// ---- psa_top.sv ----
`timescale 1ns/1ns
module psa_top import psa_pkg::*; #(
   parameter int          TICK_CYC   = TICK_CYCLES,
   parameter int          WIN_MAX    = MAX_WIN,
   parameter logic [23:0] FULL_SCALE = FULL_SCALE_R0
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        sample_valid,
   input  wire logic [23:0] sample_data,
   input  wire logic [2:0]  meas_range,
   output logic [31:0]      avg_data,
   output logic             avg_valid,
   output logic             zero_active,
   output logic [2:0]       zero_range,
   output logic [2:0]       dp_pos,
   output logic             unit_watts,
   output logic             freq_error,
   output logic             zero_error
);
   localparam int TW = $clog2(TICK_CYC);
   localparam int NPTS = NUM_SENSORS * NUM_FPTS;

   psa_div_if #(.DW(48), .VW(32)) dv ();
   psa_div #(.DW(48), .VW(32)) u_div (.core_clk(core_clk), .rst(rst), .dv(dv));

   logic [TW-1:0]  tcnt_q, tcnt_d;
   logic           tick;
   logic [23:0]    samp_q, samp_d;
   logic           wpend_q, wpend_d;
   logic [11:0]    waddr_q, waddr_d;
   logic [31:0]    rd_q, rd_d;
   logic [8:0]     ctrl_q, ctrl_d;
   logic [15:0]    filt_q, filt_d;
   logic [15:0]    freq_q, freq_d;
   logic           zerr_q, zerr_d, ferr_q, ferr_d;
   logic [31:0]    lin_mem [0:31];
   logic [5:0]     fcnt_mem [0:NUM_SENSORS-1];
   logic [31:0]    fpt_mem [0:NPTS-1];
   logic [23:0]    zoff_q [0:ZERO_RANGES-1];
   logic [31:0]    win_buf [0:MAX_WIN-1];
   logic           ap, wr;
   logic [11:0]    fpt_off, rfpt_off;
   logic           zbusy_q, zbusy_d;
   logic [2:0]     zrng_q, zrng_d;
   logic [4:0]     zcnt_q, zcnt_d;
   logic [28:0]    zsum_q, zsum_d;
   logic [6:0]     ztot_q, ztot_d;
   logic           zoff_we, zstart, zerr_set;
   logic [28:0]    zacc;
   psa_proc_t      st_q, st_d;
   logic [5:0]     p_q, p_d;
   logic [31:0]    lin_q, lin_d;
   logic [15:0]    cf_q, cf_d, c0_q, c0_d;
   logic           neg_q, neg_d, ferr_set;
   logic [8:0]     wptr_q, wptr_d, cnt_q, cnt_d, lastn_q, lastn_d;
   logic [40:0]    sum_q, sum_d;
   logic [31:0]    avg_q, avg_d;
   logic           avgv_q, avgv_d, buf_we;
   logic [8:0]     old_idx;
   logic [2:0]     act_rng, dp_q, dp_d;
   logic           unit_q, unit_d;
   logic [15:0]    wms;
   logic [16:0]    wn_raw;
   logic [8:0]     win_n;
   logic [23:0]    zval;
   logic [4:0]     lidx;
   logic [15:0]    up;
   logic signed [15:0] dn;
   logic [63:0]    sq;
   logic signed [49:0] term_s, ls_s;
   logic [31:0]    lin2, y, diff;
   logic [47:0]    yp;
   logic [7:0]     idx0;
   logic [5:0]     fcn;
   logic [15:0]    f0, f1, c0, c1;
   logic           flush;

   // sample tick, one enable pulse per sample period
   assign tick = (tcnt_q == TW'(TICK_CYC - 1));
   assign tcnt_d = tick ? '0 : tcnt_q + TW'(1);
   assign samp_d = sample_valid ? sample_data : samp_q;

   // bus slave: zero wait, write data taken in data phase
   assign ap = hsel && htrans[1] && hready;
   assign wr = wpend_q;
   assign wpend_d = ap && hwrite;
   assign waddr_d = ap ? haddr[11:0] : waddr_q;
   assign fpt_off = waddr_q - REG_FPT;
   assign rfpt_off = haddr[11:0] - REG_FPT;
   assign zstart = wr && (waddr_q == REG_CMD) && hwdata[0] && !zbusy_q;

   always_comb begin
      ctrl_d = ctrl_q;
      filt_d = filt_q;
      freq_d = freq_q;
      if (wr && waddr_q == REG_CTRL) ctrl_d = hwdata[8:0];
      if (wr && waddr_q == REG_FILT) filt_d = hwdata[15:0];
      if (wr && waddr_q == REG_FREQ) freq_d = hwdata[15:0];
      // set wins over a clear written in the same cycle
      zerr_d = zerr_set || (zerr_q && !(wr && waddr_q == REG_STAT && hwdata[ST_ZERR]));
      ferr_d = ferr_set || (ferr_q && !(wr && waddr_q == REG_STAT && hwdata[ST_FERR]));
      rd_d = rd_q;
      if (ap && !hwrite) begin
         rd_d = 32'h0000_0000;
         if (haddr[11:0] == REG_CTRL) rd_d = {23'h00_0000, ctrl_q};
         else if (haddr[11:0] == REG_FILT) rd_d = {16'h0000, filt_q};
         else if (haddr[11:0] == REG_FREQ) rd_d = {16'h0000, freq_q};
         else if (haddr[11:0] == REG_STAT) rd_d = {17'h0_0000, ztot_q, 5'h00, ferr_q, zerr_q, zbusy_q};
         else if (haddr[11:0] == REG_AVG) rd_d = avg_q;
         else if (haddr[11:0] == REG_CNT) rd_d = {7'h00, lastn_q, 7'h00, cnt_q};
         else if (haddr[11:5] == REG_ZOFF[11:5] && haddr[4:2] < 3'(ZERO_RANGES))
            rd_d = {8'h00, zoff_q[haddr[4:2]]};
         else if (haddr[11:7] == REG_LIN[11:7]) rd_d = lin_mem[haddr[6:2]];
         else if (haddr[11:4] == REG_FCNT[11:4]) rd_d = {26'h000_0000, fcnt_mem[haddr[3:2]]};
         else if (haddr[11:0] >= REG_FPT && rfpt_off[11:2] < 10'(NPTS)) rd_d = fpt_mem[rfpt_off[9:2]];
      end
   end

   // calibration tables: four sensors, eight pairs and 36 points each
   always_ff @(posedge core_clk) begin
      if (wr && waddr_q[11:7] == REG_LIN[11:7]) lin_mem[waddr_q[6:2]] <= hwdata;
      if (wr && waddr_q >= REG_FPT && fpt_off[11:2] < 10'(NPTS)) fpt_mem[fpt_off[9:2]] <= hwdata;
      if (rst) begin
         for (int i = 0; i < NUM_SENSORS; i++) fcnt_mem[i] <= 6'h00;
      end else if (wr && waddr_q[11:4] == REG_FCNT[11:4]) begin
         fcnt_mem[waddr_q[3:2]] <= hwdata[5:0];
      end
   end

   // zeroing: fixed slot of ticks per range, starts on the command edge
   assign zacc = zsum_q + 29'(samp_q);
   always_comb begin
      zbusy_d = zbusy_q;
      zrng_d = zrng_q;
      zcnt_d = zcnt_q;
      zsum_d = zsum_q;
      ztot_d = ztot_q;
      zoff_we = 1'b0;
      zerr_set = 1'b0;
      if (zstart) begin
         zbusy_d = 1'b1;
         zrng_d = 3'h0;
         zcnt_d = 5'h00;
         zsum_d = '0;
         ztot_d = 7'h00;
      end else if (zbusy_q && tick) begin
         if (zrng_q == 3'h0 && samp_q >= FULL_SCALE) begin
            zbusy_d = 1'b0;
            zerr_set = 1'b1;
         end else begin
            zsum_d = zacc;
            zcnt_d = zcnt_q + 5'h01;
            ztot_d = ztot_q + 7'h01;
            if (zcnt_q == 5'(ZERO_TICKS - 1)) begin
               zoff_we = 1'b1;
               zsum_d = '0;
               zcnt_d = 5'h00;
               if (zrng_q == 3'(ZERO_RANGES - 1)) zbusy_d = 1'b0;
               else zrng_d = zrng_q + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < ZERO_RANGES; i++) zoff_q[i] <= 24'h00_0000;
      end else if (zoff_we) begin
         zoff_q[zrng_q] <= 24'(zacc / 29'(ZERO_TICKS));
      end
   end

   // range, display hold and window length
   assign act_rng = ctrl_q[CTRL_HOLD] ? ctrl_q[CTRL_HRNG +: 3] : meas_range;
   assign dp_d = act_rng;
   assign unit_d = ctrl_q[CTRL_HOLD] ? unit_q : ctrl_q[CTRL_UNIT];
   assign wms = ctrl_q[CTRL_AUTO] ? ((act_rng == 3'h0) ? DEF_MS_R0 : DEF_MS_RX) : filt_q;
   assign wn_raw = 17'((32'(wms) + 32'(SAMPLE_MS / 2)) / 32'(SAMPLE_MS));
   assign win_n = (wn_raw == 17'h0_0000) ? 9'h001 :
                  (wn_raw > 17'(WIN_MAX)) ? 9'(WIN_MAX) : wn_raw[8:0];

   // zero correction only on the lowest ranges
   assign zval = (act_rng < 3'(ZERO_RANGES)) ?
                 ((samp_q > zoff_q[act_rng]) ? samp_q - zoff_q[act_rng] : 24'h00_0000) : samp_q;

   // linearity pair; range 0 borrows the range 1 pair
   assign lidx = {ctrl_q[CTRL_SENS +: 2], (act_rng == 3'h0) ? 3'h1 : act_rng};
   assign up = lin_mem[lidx][15:0];
   assign dn = $signed(lin_mem[lidx][31:16]);
   assign sq = 64'(lin_q) * 64'(lin_q);
   assign term_s = $signed({1'b0, sq[SQ_SHIFT +: 32]}) * dn;
   assign ls_s = $signed({18'h0_0000, lin_q}) + (term_s >>> DN_SHIFT);
   assign lin2 = ls_s[49] ? 32'h0000_0000 : (ls_s[48:32] != 17'h0_0000) ? 32'hFFFF_FFFF : ls_s[31:0];
   assign yp = 48'(lin2) * 48'(cf_q);
   assign y = (yp[47:46] != 2'b00) ? 32'hFFFF_FFFF : yp[45:14];

   // frequency points of the selected sensor
   assign idx0 = 8'(ctrl_q[CTRL_SENS +: 2] * NUM_FPTS) + 8'(p_q);
   assign fcn = (fcnt_mem[ctrl_q[CTRL_SENS +: 2]] > 6'(NUM_FPTS)) ? 6'(NUM_FPTS) : fcnt_mem[ctrl_q[CTRL_SENS +: 2]];
   assign f0 = fpt_mem[idx0][15:0];
   assign c0 = fpt_mem[idx0][31:16];
   assign f1 = fpt_mem[8'(idx0 + 8'h01)][15:0];
   assign c1 = fpt_mem[8'(idx0 + 8'h01)][31:16];

   // sliding window bookkeeping
   assign diff = (y > avg_q) ? y - avg_q : avg_q - y;
   assign flush = (win_n != lastn_q) || (ctrl_q[CTRL_AUTO] && cnt_q != 9'h000 &&
                  (64'(diff) * 64'(FLUSH_DEN) >= 64'(avg_q) * 64'(FLUSH_NUM)));
   assign old_idx = (wptr_q >= win_n) ? wptr_q - win_n : 9'(wptr_q + 9'(WIN_MAX) - win_n);

   always_comb begin
      st_d = st_q;
      p_d = p_q;
      lin_d = lin_q;
      cf_d = cf_q;
      c0_d = c0_q;
      neg_d = neg_q;
      ferr_set = 1'b0;
      wptr_d = wptr_q;
      cnt_d = cnt_q;
      sum_d = sum_q;
      lastn_d = lastn_q;
      avg_d = avg_q;
      avgv_d = 1'b0;
      buf_we = 1'b0;
      dv.start = 1'b0;
      dv.dividend = '0;
      dv.divisor = '0;
      unique case (st_q)
         P_IDLE: begin
            if (tick && !zbusy_q) begin
               dv.start = 1'b1;
               dv.dividend = 48'(40'(zval) * 40'(up));
               dv.divisor = 32'(UP_NOM);
               st_d = P_LIN;
            end
         end
         P_LIN: begin
            if (dv.done) begin
               lin_d = (dv.quotient[47:32] != 16'h0000) ? 32'hFFFF_FFFF : dv.quotient[31:0];
               p_d = 6'h00;
               cf_d = CF_UNITY;
               st_d = ctrl_q[CTRL_FEN] ? P_SCAN : P_AVG;
            end
         end
         P_SCAN: begin
            if (fcn == 6'h00) begin
               ferr_set = 1'b1;
               st_d = P_AVG;
            end else if (freq_q == f0) begin
               cf_d = c0;
               st_d = P_AVG;
            end else if (p_q + 6'h01 < fcn && f0 < freq_q && freq_q < f1) begin
               dv.start = 1'b1;
               dv.dividend = 48'(((c1 > c0) ? 33'(c1 - c0) : 33'(c0 - c1)) * 33'(freq_q - f0));
               dv.divisor = 32'(f1 - f0);
               neg_d = c1 < c0;
               c0_d = c0;
               st_d = P_IDIV;
            end else if (p_q + 6'h01 >= fcn) begin
               ferr_set = 1'b1;
               st_d = P_AVG;
            end else begin
               p_d = p_q + 6'h01;
            end
         end
         P_IDIV: begin
            if (dv.done) begin
               cf_d = neg_q ? c0_q - dv.quotient[15:0] : c0_q + dv.quotient[15:0];
               st_d = P_AVG;
            end
         end
         P_AVG: begin
            buf_we = 1'b1;
            lastn_d = win_n;
            wptr_d = (wptr_q == 9'(WIN_MAX - 1)) ? 9'h000 : wptr_q + 9'h001;
            if (flush) begin
               sum_d = 41'(y);
               cnt_d = 9'h001;
            end else if (cnt_q < win_n) begin
               sum_d = sum_q + 41'(y);
               cnt_d = cnt_q + 9'h001;
            end else begin
               sum_d = sum_q + 41'(y) - 41'(win_buf[old_idx]);
            end
            dv.start = 1'b1;
            dv.dividend = 48'(sum_d);
            dv.divisor = 32'(cnt_d);
            st_d = P_MDIV;
         end
         P_MDIV: begin
            if (dv.done) begin
               avg_d = dv.quotient[31:0];
               avgv_d = 1'b1;
               st_d = P_IDLE;
            end
         end
      endcase
   end

   // window store of 400 words; depth trades area for the 20 s maximum
   always_ff @(posedge core_clk) begin
      if (buf_we) win_buf[wptr_q] <= y;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tcnt_q <= '0;
         samp_q <= 24'h00_0000;
         wpend_q <= 1'b0;
         waddr_q <= 12'h000;
         rd_q <= 32'h0000_0000;
         ctrl_q <= CTRL_RESET;
         filt_q <= FILT_RESET;
         freq_q <= 16'h0000;
         zerr_q <= 1'b0;
         ferr_q <= 1'b0;
         zbusy_q <= 1'b0;
         zrng_q <= 3'h0;
         zcnt_q <= 5'h00;
         zsum_q <= '0;
         ztot_q <= 7'h00;
         st_q <= P_IDLE;
         p_q <= 6'h00;
         lin_q <= 32'h0000_0000;
         cf_q <= CF_UNITY;
         c0_q <= 16'h0000;
         neg_q <= 1'b0;
         wptr_q <= 9'h000;
         cnt_q <= 9'h000;
         sum_q <= '0;
         lastn_q <= 9'h000;
         avg_q <= 32'h0000_0000;
         avgv_q <= 1'b0;
         dp_q <= 3'h0;
         unit_q <= CTRL_RESET[CTRL_UNIT];
      end else begin
         tcnt_q <= tcnt_d;
         samp_q <= samp_d;
         wpend_q <= wpend_d;
         waddr_q <= waddr_d;
         rd_q <= rd_d;
         ctrl_q <= ctrl_d;
         filt_q <= filt_d;
         freq_q <= freq_d;
         zerr_q <= zerr_d;
         ferr_q <= ferr_d;
         zbusy_q <= zbusy_d;
         zrng_q <= zrng_d;
         zcnt_q <= zcnt_d;
         zsum_q <= zsum_d;
         ztot_q <= ztot_d;
         st_q <= st_d;
         p_q <= p_d;
         lin_q <= lin_d;
         cf_q <= cf_d;
         c0_q <= c0_d;
         neg_q <= neg_d;
         wptr_q <= wptr_d;
         cnt_q <= cnt_d;
         sum_q <= sum_d;
         lastn_q <= lastn_d;
         avg_q <= avg_d;
         avgv_q <= avgv_d;
         dp_q <= dp_d;
         unit_q <= unit_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rd_q;
   assign avg_data = avg_q;
   assign avg_valid = avgv_q;
   assign zero_active = zbusy_q;
   assign zero_range = zrng_q;
   assign dp_pos = dp_q;
   assign unit_watts = unit_q;
   assign freq_error = ferr_q;
   assign zero_error = zerr_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_tick_accept: assert property (st_q == P_IDLE && tick && !zbusy_q |=> st_q == P_LIN)
      else $error("sample tick not taken");
   a_win_bounds: assert property (st_q == P_AVG |-> win_n >= 9'h001 && win_n <= 9'(WIN_MAX))
      else $error("window length out of bounds");
   a_auto_len: assert property (ctrl_q[CTRL_AUTO] |-> win_n == ((act_rng == 3'h0) ? 9'h038 : 9'h010))
      else $error("default window length wrong");
   a_mean_exact: assert property (avgv_q |-> 64'(avg_q) * 64'(cnt_q) <= 64'(sum_q) &&
         64'(sum_q) < (64'(avg_q) + 64'h0000_0000_0000_0001) * 64'(cnt_q))
      else $error("mean not sum over count");
   a_zero_start: assert property (zstart |=> zbusy_q && zrng_q == 3'h0 && ztot_q == 7'h00)
      else $error("zeroing did not start at once");
   a_zero_abort: assert property (zbusy_q && tick && zrng_q == 3'h0 && samp_q >= FULL_SCALE
         && !zstart |=> !zbusy_q && zerr_q)
      else $error("overrange zeroing not aborted");
   a_zero_time: assert property ($fell(zbusy_q) && !zerr_set && !$past(zerr_set) |->
         ztot_q == 7'(ZERO_TICKS * ZERO_RANGES))
      else $error("zeroing length wrong");
   a_high_nocorr: assert property (act_rng >= 3'(ZERO_RANGES) |-> zval == samp_q)
      else $error("upper range corrected");
   a_freq_flag: assert property (st_q == P_SCAN && fcn != 6'h00 && freq_q != f0 && p_q + 6'h01 >= fcn
         |=> ferr_q ##0 st_q == P_AVG ##0 cf_q == CF_UNITY)
      else $error("out of span not flagged");
   a_hold_dp: assert property (ctrl_q[CTRL_HOLD] && $past(ctrl_q[CTRL_HOLD]) && $stable(ctrl_q)
         |=> $stable(dp_q) && $stable(unit_q))
      else $error("held range display moved");
endmodule : psa_top

// ---- psa_src.sv ----
`timescale 1ns/1ns
// front-end sample stream, one valid pulse every 10 clocks
module psa_src (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [23:0] level,
   input  wire logic [2:0]  range_in,
   output logic             sample_valid,
   output logic [23:0]      sample_data,
   output logic [2:0]       meas_range
);
   logic [3:0] div_q;
   always_ff @(posedge core_clk) begin
      div_q        <= (rst || div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
      sample_valid <= !rst && div_q == 4'h9;
      // inverted between pulses so a stale value never looks right
      sample_data  <= (div_q == 4'h9) ? level : ~level;
      meas_range   <= range_in;
   end
endmodule : psa_src

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
   import psa_pkg::*;
   localparam int TC = 300;
   logic        core_clk = 0, rst = 1, hsel = 0, hwrite = 0, sv, hro, hrsp, avg_valid, za, uw, fe, ze;
   logic [1:0]  htrans = 0;
   logic [2:0]  mr, zr, dp, rng = 0;
   logic [23:0] sd, lvl = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, avg_data, rd, v, seed = 32'h0000_3058;
   logic [31:0] q[$];
   int          n_mismatch = 0, n_tests = 0, n, k, j;
   int          ms_tab[3] = '{50, 150, 200};
   initial forever #50 core_clk = ~core_clk;
   psa_src u_psa_src (.core_clk, .rst, .level(lvl), .range_in(rng), .sample_valid(sv), .sample_data(sd),
      .meas_range(mr));
   psa_top #(.TICK_CYC(TC)) u_psa_top (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hro), .hreadyout(hro), .hresp(hrsp), .hrdata, .sample_valid(sv), .sample_data(sd), .meas_range(mr),
      .avg_data, .avg_valid, .zero_active(za), .zero_range(zr), .dp_pos(dp), .unit_watts(uw), .freq_error(fe),
      .zero_error(ze));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [31:0] mean();
      logic [31:0] s;
      s = 0;
      foreach (q[i]) s += q[i];
      return s / q.size();
   endfunction : mean
   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // single word transfer; waits on hready, no assumed latency
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0_0000, a};
      do @(posedge core_clk); while (hro !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hro !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic tick();
      for (int i = 0; i < 3 * TC; i++) begin
         @(posedge core_clk);
         #1;
         if (avg_valid === 1'b1) return;
      end
      chk(0, 1);
   endtask : tick
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      for (k = 1; k < 7; k++) bus(1, REG_LIN + 12'(4 * k), 32'h0000_1388);
      bus(0, REG_FILT, 0);
      chk(rd, 32'h0000_0032);
      chk(hrsp, 32'h0000_0000);
      bus(0, 12'h01C, 0);
      chk(rd, 32'h0000_0000);
      tick();
      tick();
      bus(0, REG_CNT, 0);
      chk(rd[24:16], 32'h0000_0038);
      rng <= 1;
      tick();
      tick();
      bus(0, REG_CNT, 0);
      chk(rd[24:16], 32'h0000_0010);
      bus(1, REG_CTRL, 32'h0000_0080);
      tick();
      foreach (ms_tab[t]) begin
         bus(1, REG_FILT, ms_tab[t]);
         n = (ms_tab[t] + 25) / 50;
         q.delete();
         for (k = 0; k < 7; k++) begin
            v = xs() & 32'h0000_FFFF;
            lvl <= v[23:0];
            q.push_back(v);
            if (q.size() > n) void'(q.pop_front());
            tick();
            chk(avg_data, mean());
         end
      end
      for (j = 0; j < 2; j++) begin
         bus(1, REG_FILT, 20000 + 10000 * j);
         tick();
         tick();
         bus(0, REG_CNT, 0);
         chk(rd[24:16], 32'h0000_0190);
      end
      // auto filter: a step well above 0.02 dB must restart the window
      bus(1, REG_CTRL, 32'h0000_0081);
      lvl <= 24'h00_03E8;
      tick();
      tick();
      chk(avg_data, 32'h0000_03E8);
      lvl <= 24'h00_07D0;
      tick();
      chk(avg_data, 32'h0000_07D0);
      bus(1, REG_CTRL, 32'h0000_0080);
      lvl <= 24'h00_000A;
      tick();
      bus(1, REG_CMD, 32'h0000_0001);
      @(posedge core_clk);
      #1 chk(za, 1);
      chk(zr, 0);
      for (n = 1; n < 200 * TC && za === 1'b1; n++) @(posedge core_clk);
      chk((n + TC / 2) / TC, 100);
      for (k = 0; k < 5; k++) begin
         bus(0, REG_ZOFF + 12'(4 * k), 0);
         chk(rd, 32'h0000_000A);
      end
      bus(1, REG_FILT, 50);
      for (j = 2; j < 6; j += 3) begin
         rng <= 3'(j);
         lvl <= 24'h00_006E;
         tick();
         tick();
         chk(avg_data, (j < 5) ? 32'h0000_0064 : 32'h0000_006E);
      end
      bus(1, REG_CTRL, 32'h0000_008E);
      tick();
      rng <= 4;
      tick();
      tick();
      chk(dp, 3);
      // unit bit cleared while held must not reach the output
      bus(1, REG_CTRL, 32'h0000_000E);
      tick();
      chk(uw, 1);
      chk(dp, 3);
      bus(1, REG_CTRL, 32'h0000_0180);
      tick();
      tick();
      chk(fe, 1);
      // ascending points, unity at zero frequency; 150 lies midway 100..200
      bus(1, REG_FPT, 32'h4000_0000);
      bus(1, REG_FPT + 12'h004, 32'h4000_0064);
      bus(1, REG_FPT + 12'h008, 32'h6000_00C8);
      bus(1, REG_FCNT, 32'h0000_0003);
      bus(1, REG_FREQ, 32'h0000_0096);
      bus(1, REG_STAT, 32'h0000_0004);
      tick();
      tick();
      chk(avg_data, 32'h0000_007D);
      chk(fe, 0);
      bus(1, REG_FREQ, 32'h0000_012C);
      tick();
      tick();
      chk(fe, 1);
      chk(avg_data, 32'h0000_0064);
      // range 0 must take the range 1 pair, not slot 0
      bus(1, REG_LIN, 32'h0000_1388);
      bus(1, REG_LIN + 12'h004, 32'h0000_2710);
      rng <= 0;
      tick();
      tick();
      chk(avg_data, 32'h0000_00C8);
      rng <= 0;
      lvl <= FULL_SCALE_R0;
      tick();
      bus(1, REG_CMD, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      for (n = 0; n < 5 * TC && za === 1'b1; n++) @(posedge core_clk);
      #1 chk(ze, 1);
      conclude();
   end
   initial begin
      repeat (80000) @(posedge core_clk);
      n_mismatch++;
      conclude();
   end
endmodule : tb_top
